/* design/evic_pkg.sv */
// Shared constants for the eight-level vectored interrupt controller
package evic_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 8;
  localparam int BYTE_W    = 8;

  // ----------------------------------------------------------------
  // Register select codes {select_addr_x, select_addr_y}
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_FETCH_OR_PAGE = 2'h2;
  localparam logic [1:0] SEL_POLL_OR_CTRL  = 2'h1;
  localparam logic [1:0] SEL_STAT_OR_MASK  = 2'h0;
  localparam logic [1:0] SEL_UNUSED        = 2'h3;

  // ----------------------------------------------------------------
  // Control byte fields
  // ----------------------------------------------------------------
  localparam int CTRL_INTERVAL_LSB = 0;
  localparam int CTRL_MASK_RST_BIT = 2;
  localparam int CTRL_REQ_RST_BIT  = 3;
  localparam int CTRL_LOWADDR_LSB  = 4;

  // Interval select codes
  localparam logic [1:0] INTERVAL_2  = 2'h0;
  localparam logic [1:0] INTERVAL_4  = 2'h1;
  localparam logic [1:0] INTERVAL_8  = 2'h2;
  localparam logic [1:0] INTERVAL_16 = 2'h3;

  // ----------------------------------------------------------------
  // Vector response
  // ----------------------------------------------------------------
  localparam logic [7:0] LONG_BRANCH_OPCODE = 8'hC0;
  localparam logic [1:0] FETCH_BYTE_OPCODE  = 2'h0;
  localparam logic [1:0] FETCH_BYTE_PAGE    = 2'h1;
  localparam logic [1:0] FETCH_BYTE_LOW     = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

endpackage : evic_pkg

/* design/evic_req_latch.sv */
// One request line: falling-edge latch with single and global clear
module evic_req_latch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic requestLineN,
  input  wire logic clearOne,
  input  wire logic clearAll,
  output logic      pending
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prevLevel;
    logic pend;
  } evic_latch_t;

  evic_latch_t state_reg;
  evic_latch_t state_next;
  logic        fallEdge;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    fallEdge             = state_reg.prevLevel & ~requestLineN;
    state_next           = state_reg;
    state_next.prevLevel = requestLineN;
    // New edge wins over a clear in the same cycle
    state_next.pend      = fallEdge | (state_reg.pend & ~clearOne & ~clearAll);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{prevLevel: 1'b1, pend: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending = state_reg.pend;

endmodule : evic_req_latch

/* design/evic_vector_sel.sv */
// Priority pick of the active request and low vector byte build
module evic_vector_sel (
  input  wire logic [7:0] requests,
  input  wire logic [7:0] controlByte,
  output logic            anyRequest,
  output logic [2:0]      topNumber,
  output logic [7:0]      lowVector
);

  // ----------------------------------------------------------------
  // Priority: line 7 highest, line 0 lowest
  // ----------------------------------------------------------------
  always_comb begin
    topNumber  = 3'h0;
    anyRequest = |requests;
    for (int i = 0; i < evic_pkg::NUM_LINES; i++) begin
      if (requests[i]) begin
        topNumber = 3'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Low vector byte
  // ----------------------------------------------------------------
  always_comb begin
    case (controlByte[evic_pkg::CTRL_INTERVAL_LSB +: 2])
      evic_pkg::INTERVAL_2:  lowVector = {controlByte[7:4], topNumber, 1'b0};
      evic_pkg::INTERVAL_4:  lowVector = {controlByte[7:5], topNumber, 2'h0};
      evic_pkg::INTERVAL_8:  lowVector = {controlByte[7:6], topNumber, 3'h0};
      evic_pkg::INTERVAL_16: lowVector = {controlByte[7], topNumber, 4'h0};
      default:               lowVector = 8'h00;
    endcase
  end

endmodule : evic_vector_sel

/* design/evic_top.sv */
// Eight-level vectored interrupt controller on a strobed 8-bit CPU bus
// How it works
// - Write-only page byte gives vector high byte
// - Control bits 1..0 pick 2/4/8/16 interval
// - Control mask-clear bit zero clears all masks
// - Control request-clear bit zero clears all latches
// - Request-clear bit sits at control bit 3
// - Control bits 7..4 give low vector bits
// - Request number fills the three bits above the zeros, over ignored bits
// - Low byte: upper bits, request number, zeros
// - Mask bit one blocks that line's interrupt
// - Chain priority input is never masked
// - Status read shows every pending request
// - Poll read returns current low vector byte
// - Vector fetch drives exactly three bytes
// - First fetch byte is long-branch opcode C0
// - Second fetch byte is page byte unchanged
// - Selects high at first pulse, code at second
// - Read codes: fetch, poll, status, unused
// - Write codes: page, control, mask
// - Fetch vectors highest unmasked pending request
// - Chained controllers decide locally who answers
module evic_top #(
  parameter int NUM_LINES = evic_pkg::NUM_LINES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [NUM_LINES-1:0] requestLinesN,
  input  wire logic                 chainPriorityInN,
  input  wire logic                 readStrobeN,
  input  wire logic                 writeStrobeN,
  input  wire logic                 firstTimingPulse,
  input  wire logic                 secondTimingPulse,
  input  wire logic                 chipSelect,
  input  wire logic                 chipSelectN,
  input  wire logic                 selectAddrX,
  input  wire logic                 selectAddrY,
  input  wire logic [7:0]           dataLinesIn,
  output logic      [7:0]           dataLinesOut,
  output logic                      dataLinesOe,
  output logic                      interruptOutN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pageByte;
    logic [7:0] controlByte;
    logic [7:0] maskByte;
    logic       selected;
    logic       codeValid;
    logic [1:0] selCode;
    logic       readPrevN;
    logic       writePrevN;
    logic [1:0] fetchIdx;
    logic       fetchOwner;
    logic [2:0] servedNumber;
    logic [7:0] dataOut;
    logic       dataOe;
    logic       intN;
  } evic_state_t;

  evic_state_t state_reg;
  evic_state_t state_next;

  logic [NUM_LINES-1:0] pendingBits;
  logic [NUM_LINES-1:0] unmaskedBits;
  logic [NUM_LINES-1:0] clearOne;
  logic                 clearAll;
  logic                 anyUnmasked;
  logic [2:0]           topNumber;
  logic [7:0]           pollByte;
  logic [7:0]           servedLow;
  logic                 readStart;
  logic                 readEnd;
  logic                 writeStart;
  logic                 ownNow;
  logic [7:0]           readByte;
  logic                 readDrives;
  logic                 enableNow;
  logic                 fetchSel;
  logic                 opcodeStart;
  logic                 ctrlWrite;
  logic                 driveNext;
  logic                 intNext;

  // ----------------------------------------------------------------
  // Request latches
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : gLine
      evic_req_latch uLatch (
        .clk          (clk),
        .rst_n        (rst_n),
        .requestLineN (requestLinesN[g]),
        .clearOne     (clearOne[g]),
        .clearAll     (clearAll),
        .pending      (pendingBits[g])
      );
    end
  endgenerate

  assign unmaskedBits = pendingBits & ~state_reg.maskByte;

  // ----------------------------------------------------------------
  // Priority and vector composition
  // ----------------------------------------------------------------
  evic_vector_sel uPick (
    .requests    (unmaskedBits),
    .controlByte (state_reg.controlByte),
    .anyRequest  (anyUnmasked),
    .topNumber   (topNumber),
    .lowVector   (pollByte)
  );

  // Low byte for the request frozen at the start of a fetch
  evic_vector_sel uServed (
    .requests    (8'(1) << state_reg.servedNumber),
    .controlByte (state_reg.controlByte),
    .anyRequest  (),
    .topNumber   (),
    .lowVector   (servedLow)
  );

  // ----------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------
  always_comb begin
    readStart  = state_reg.readPrevN & ~readStrobeN & state_reg.codeValid;
    readEnd    = ~state_reg.readPrevN & readStrobeN & state_reg.codeValid;
    writeStart = state_reg.writePrevN & ~writeStrobeN & state_reg.codeValid;
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  always_comb begin
    enableNow   = chipSelect & ~chipSelectN & selectAddrX & selectAddrY;
    fetchSel    = (state_reg.selCode == evic_pkg::SEL_FETCH_OR_PAGE);
    opcodeStart = readStart & fetchSel
                & (state_reg.fetchIdx == evic_pkg::FETCH_BYTE_OPCODE);
    ctrlWrite   = writeStart & (state_reg.selCode == evic_pkg::SEL_POLL_OR_CTRL);
  end

  // ----------------------------------------------------------------
  // Fetch ownership
  // ----------------------------------------------------------------
  // Decided once, at the strobe edge of the opcode byte; the rest of the
  // fetch reuses it, so the drive holds after the served latch clears
  always_comb begin
    ownNow = opcodeStart ? (anyUnmasked & chainPriorityInN)
                         : state_reg.fetchOwner;
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  always_comb begin
    readByte   = 8'h00;
    readDrives = 1'b0;
    case (state_reg.selCode)
      evic_pkg::SEL_FETCH_OR_PAGE: begin
        readDrives = ownNow;
        case (state_reg.fetchIdx)
          evic_pkg::FETCH_BYTE_OPCODE: readByte = evic_pkg::LONG_BRANCH_OPCODE;
          evic_pkg::FETCH_BYTE_PAGE:   readByte = state_reg.pageByte;
          evic_pkg::FETCH_BYTE_LOW:    readByte = servedLow;
          default:                     readByte = 8'h00;
        endcase
      end
      evic_pkg::SEL_STAT_OR_MASK: begin
        readDrives = 1'b1;
        readByte   = pendingBits;
      end
      evic_pkg::SEL_POLL_OR_CTRL: begin
        readDrives = 1'b1;
        readByte   = pollByte;
      end
      default: begin
        readDrives = 1'b0;
        readByte   = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Clears to the request latches
  // ----------------------------------------------------------------
  always_comb begin
    clearOne = '0;
    clearAll = 1'b0;
    if (opcodeStart && ownNow) begin
      clearOne[topNumber] = 1'b1;
    end
    if (ctrlWrite) begin
      clearAll = ~dataLinesIn[evic_pkg::CTRL_REQ_RST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Data bus drive
  // ----------------------------------------------------------------
  // Held while the read strobe is low; dropped on the strobe's release
  always_comb begin
    driveNext = state_reg.codeValid & ~readStrobeN & readDrives & ~readEnd;
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Lines cleared in this cycle no longer hold the output low
  always_comb begin
    intNext = ~(|(unmaskedBits & ~clearOne) & ~clearAll);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next            = state_reg;
    state_next.readPrevN  = readStrobeN;
    state_next.writePrevN = writeStrobeN;

    // Chip enable is sampled at the first pulse only
    if (firstTimingPulse) begin
      state_next.selected  = enableNow;
      state_next.codeValid = 1'b0;
    end
    // Register code is taken at the second pulse
    if (secondTimingPulse && state_reg.selected) begin
      state_next.selCode   = {selectAddrX, selectAddrY};
      state_next.codeValid = 1'b1;
    end

    // Writes
    if (writeStart) begin
      case (state_reg.selCode)
        evic_pkg::SEL_FETCH_OR_PAGE: state_next.pageByte = dataLinesIn;
        evic_pkg::SEL_POLL_OR_CTRL: begin
          state_next.controlByte = dataLinesIn;
          if (!dataLinesIn[evic_pkg::CTRL_MASK_RST_BIT]) begin
            state_next.maskByte = 8'h00;
          end
        end
        evic_pkg::SEL_STAT_OR_MASK:  state_next.maskByte = dataLinesIn;
        default:                     state_next.maskByte = state_reg.maskByte;
      endcase
    end

    // Fetch bookkeeping
    if (opcodeStart) begin
      state_next.fetchOwner   = ownNow;
      state_next.servedNumber = topNumber;
    end
    if (readEnd && fetchSel) begin
      state_next.fetchIdx = (state_reg.fetchIdx == evic_pkg::FETCH_BYTE_LOW)
                          ? evic_pkg::FETCH_BYTE_OPCODE
                          : state_reg.fetchIdx + 2'h1;
    end
    if (readEnd || writeStart) begin
      state_next.codeValid = 1'b0;
    end

    state_next.dataOe  = driveNext;
    state_next.dataOut = readByte;
    state_next.intN    = intNext;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{pageByte:     evic_pkg::PAGE_RESET,
                     controlByte:  evic_pkg::CTRL_RESET,
                     maskByte:     evic_pkg::MASK_RESET,
                     selected:     1'b0,
                     codeValid:    1'b0,
                     selCode:      evic_pkg::SEL_UNUSED,
                     readPrevN:    1'b1,
                     writePrevN:   1'b1,
                     fetchIdx:     evic_pkg::FETCH_BYTE_OPCODE,
                     fetchOwner:   1'b0,
                     servedNumber: 3'h0,
                     dataOut:      8'h00,
                     dataOe:       1'b0,
                     intN:         1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dataLinesOut  = state_reg.dataOut;
  assign dataLinesOe   = state_reg.dataOe;
  assign interruptOutN = state_reg.intN;

endmodule : evic_top

/* verification/evic_chk.sv */
// Bus-side assertions for the interrupt controller
module evic_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       chainPriorityInN,
  input wire logic       readStrobeN,
  input wire logic       writeStrobeN,
  input wire logic       firstTimingPulse,
  input wire logic       secondTimingPulse,
  input wire logic       chipSelect,
  input wire logic       chipSelectN,
  input wire logic       selectAddrX,
  input wire logic       selectAddrY,
  input wire logic [7:0] dataLinesIn,
  input wire logic [7:0] dataLinesOut,
  input wire logic       dataLinesOe
);
  logic       enReg;
  logic       haveCode;
  logic [1:0] codeReg;
  logic [1:0] fetchIdx;
  logic [7:0] pageReg;

  // Shadow of the select decode, fetch byte position and page byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enReg    <= 1'b0;
      haveCode <= 1'b0;
      codeReg  <= 2'h0;
      fetchIdx <= 2'h0;
      pageReg  <= 8'h00;
    end else begin
      if (firstTimingPulse) begin
        enReg    <= chipSelect & ~chipSelectN & selectAddrX & selectAddrY;
        haveCode <= 1'b0;
      end
      if (secondTimingPulse && enReg) begin
        codeReg  <= {selectAddrX, selectAddrY};
        haveCode <= 1'b1;
      end
      if ($rose(readStrobeN) && haveCode && codeReg == 2'h2)
        fetchIdx <= (fetchIdx == 2'h2) ? 2'h0 : fetchIdx + 2'h1;
      if ($fell(writeStrobeN) && haveCode && codeReg == 2'h2)
        pageReg <= dataLinesIn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence readStart;
    $fell(readStrobeN) && writeStrobeN;
  endsequence
  sequence fetchStart;
    readStart ##0 (haveCode && codeReg == 2'h2 && fetchIdx == 2'h0);
  endsequence

  read_drive_a: assert property (readStart ##0 (haveCode && !codeReg[1]) |=> dataLinesOe)
    else $error("status or poll read not driven");
  bad_code_a: assert property (readStart ##0 !(haveCode && codeReg != 2'h3) |=> !dataLinesOe)
    else $error("refused read drove the bus");
  hold_drive_a: assert property (dataLinesOe && !readStrobeN |=> dataLinesOe)
    else $error("read drive dropped early");
  drop_drive_a: assert property (readStrobeN |=> !dataLinesOe)
    else $error("bus still driven after read");
  write_quiet_a: assert property ($fell(writeStrobeN) |-> ##1 !dataLinesOe [*2])
    else $error("bus driven during write");
  opcode_first_a: assert property (fetchStart ##0 chainPriorityInN |=>
    !dataLinesOe || dataLinesOut == evic_pkg::LONG_BRANCH_OPCODE)
    else $error("first fetch byte wrong");
  page_second_a: assert property ($rose(dataLinesOe) && codeReg == 2'h2 && fetchIdx == 2'h1
    |-> dataLinesOut == pageReg)
    else $error("second fetch byte differs from page");
  low_zero_a: assert property ($rose(dataLinesOe) && codeReg == 2'h2 && fetchIdx == 2'h2
    |-> !dataLinesOut[0])
    else $error("low vector bit 0 set");
  chain_block_a: assert property (fetchStart ##0 !chainPriorityInN |=> !dataLinesOe)
    else $error("fetch answered while chain low");
endmodule : evic_chk

bind evic_top evic_chk u_evic_chk (.clk(clk), .rst_n(rst_n), .chainPriorityInN(chainPriorityInN),
  .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .firstTimingPulse(firstTimingPulse),
  .secondTimingPulse(secondTimingPulse), .chipSelect(chipSelect), .chipSelectN(chipSelectN),
  .selectAddrX(selectAddrX), .selectAddrY(selectAddrY), .dataLinesIn(dataLinesIn),
  .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));

/* verification/evic_cpu_bfm.sv */
// CPU bus master model driving the controller's strobed register bus
module evic_cpu_bfm (
  input  wire logic       clk,
  input  wire logic [7:0] dataLinesOut,
  input  wire logic       dataLinesOe,
  output logic            readStrobeN,
  output logic            writeStrobeN,
  output logic            firstTimingPulse,
  output logic            secondTimingPulse,
  output logic            chipSelect,
  output logic            chipSelectN,
  output logic            selectAddrX,
  output logic            selectAddrY,
  output wire logic [7:0] dataLinesIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cpuData;

  // Shared data wire: device value while it drives, CPU value otherwise
  assign dataLinesIn = dataLinesOe ? dataLinesOut : cpuData;

  initial begin
    readStrobeN       = 1'b1;
    writeStrobeN      = 1'b1;
    firstTimingPulse  = 1'b0;
    secondTimingPulse = 1'b0;
    chipSelect        = 1'b0;
    chipSelectN       = 1'b1;
    selectAddrX       = 1'b1;
    selectAddrY       = 1'b1;
    cpuData           = 8'h5A;
  end

  task automatic access(input logic rd, input logic [1:0] code, input logic [7:0] wd,
                        output logic [7:0] rv, output logic oe);
    @(posedge clk);
    firstTimingPulse <= 1'b1;
    chipSelect       <= 1'b1;
    chipSelectN      <= 1'b0;
    selectAddrX      <= 1'b1;
    selectAddrY      <= 1'b1;
    @(posedge clk);
    firstTimingPulse            <= 1'b0;
    secondTimingPulse           <= 1'b1;
    {selectAddrX, selectAddrY} <= code;
    @(posedge clk);
    secondTimingPulse <= 1'b0;
    if (rd) begin
      readStrobeN <= 1'b0;
    end else begin
      writeStrobeN <= 1'b0;
      cpuData      <= wd;
    end
    repeat (2) @(posedge clk);
    rv = dataLinesOut;
    oe = dataLinesOe;
    readStrobeN  <= 1'b1;
    writeStrobeN <= 1'b1;
    cpuData      <= ~cpuData;
    @(posedge clk);
  endtask : access
endmodule : evic_cpu_bfm

/* verification/tb_top.sv */
// Self-checking bench for the interrupt controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst_n;
  logic       chainN;
  logic [7:0] reqN;
  logic [7:0] dOut;
  logic [7:0] dIn;
  logic       dOe, intN, rdN, wrN, tp1, tp2, cs, csN, ax, ay;
  int         failures;
  int         cmp_count;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  evic_top u_evic_top (.clk(clk), .rst_n(rst_n), .requestLinesN(reqN),
    .chainPriorityInN(chainN), .readStrobeN(rdN), .writeStrobeN(wrN),
    .firstTimingPulse(tp1), .secondTimingPulse(tp2), .chipSelect(cs), .chipSelectN(csN),
    .selectAddrX(ax), .selectAddrY(ay), .dataLinesIn(dIn), .dataLinesOut(dOut),
    .dataLinesOe(dOe), .interruptOutN(intN));
  evic_cpu_bfm u_evic_cpu_bfm (.clk(clk), .dataLinesOut(dOut), .dataLinesOe(dOe),
    .readStrobeN(rdN), .writeStrobeN(wrN), .firstTimingPulse(tp1), .secondTimingPulse(tp2),
    .chipSelect(cs), .chipSelectN(csN), .selectAddrX(ax), .selectAddrY(ay), .dataLinesIn(dIn));

  task automatic stop_test;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic cmp1(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp1

  task automatic wr(input logic [1:0] code, input logic [7:0] d);
    logic [7:0] v;
    logic       o;
    u_evic_cpu_bfm.access(1'b0, code, d, v, o);
  endtask : wr

  task automatic rd(input logic [1:0] code, input string name, input logic [7:0] exp);
    logic [7:0] v;
    logic       o;
    u_evic_cpu_bfm.access(1'b1, code, 8'h00, v, o);
    cmp1({name, " drive"}, 1'b1, o);
    cmp(name, exp, v);
  endtask : rd

  task automatic pulse(input int n);
    @(posedge clk);
    reqN <= reqN & ~(8'h01 << n);
    repeat (2) @(posedge clk);
    reqN <= 8'hFF;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mask;
    cmp1("irq idle", 1'b1, intN);
    rd(2'h0, "status", 8'h00);
    wr(2'h0, 8'h10);
    pulse(4);
    cmp1("irq masked", 1'b1, intN);
    rd(2'h0, "status", 8'h10);
    pulse(2);
    cmp1("irq raised", 1'b0, intN);
  endtask : t_mask

  task automatic t_fetch;
    wr(2'h2, 8'h84);
    wr(2'h1, 8'hCE);
    rd(2'h1, "poll", 8'hD0);
    rd(2'h2, "opcode", 8'hC0);
    rd(2'h2, "page", 8'h84);
    rd(2'h2, "low", 8'hD0);
    cmp1("irq served", 1'b1, intN);
    rd(2'h0, "status", 8'h10);
  endtask : t_fetch

  task automatic t_interval;
    logic [7:0] m;
    wr(2'h0, 8'h00);
    for (int iv = 0; iv < 4; iv++) begin
      m = 8'hF0 << iv;
      wr(2'h1, {4'hA, 2'b11, 2'(iv)});
      rd(2'h1, "poll", (8'hA0 & m) | (8'h04 << (iv + 1)));
    end
  endtask : t_interval

  task automatic t_clear;
    wr(2'h0, 8'hFF);
    pulse(1);
    cmp1("irq all masked", 1'b1, intN);
    wr(2'h1, 8'h0B);
    cmp1("irq unmasked", 1'b0, intN);
    wr(2'h1, 8'h07);
    rd(2'h0, "status", 8'h00);
    cmp1("irq cleared", 1'b1, intN);
  endtask : t_clear

  task automatic t_chain;
    logic [7:0] v;
    logic       o;
    chainN <= 1'b0;
    pulse(0);
    pulse(7);
    repeat (3) begin
      u_evic_cpu_bfm.access(1'b1, 2'h2, 8'h00, v, o);
      cmp1("chain fetch drive", 1'b0, o);
    end
    chainN <= 1'b1;
    u_evic_cpu_bfm.access(1'b1, 2'h3, 8'h00, v, o);
    cmp1("unused drive", 1'b0, o);
    wr(2'h1, 8'h0C);
    rd(2'h2, "opcode", 8'hC0);
    rd(2'h2, "page", 8'h84);
    rd(2'h2, "low top", 8'h0E);
    rd(2'h0, "status", 8'h01);
  endtask : t_chain

  initial begin
    failures  = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    reqN      = 8'hFF;
    chainN    = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_mask();
    t_fetch();
    t_interval();
    t_clear();
    t_chain();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : tb_top
